// file: rtl/sdp_map.svh
`ifndef SDP_MAP_SVH
`define SDP_MAP_SVH
// register word indices; the byte address is four times the index
`define SDP_IDX_STATIC_CTRL    8'ha1
`define SDP_IDX_DYNAMIC_CTRL   8'hb1
// register byte addresses
`define SDP_ADDR_STATIC_CTRL   {2'b00, `SDP_IDX_STATIC_CTRL, 2'b00}
`define SDP_ADDR_DYNAMIC_CTRL  {2'b00, `SDP_IDX_DYNAMIC_CTRL, 2'b00}
`define SDP_ADDR_DUTY_BASE     12'h000
`define SDP_ADDR_PORT_SEL      12'h040
`define SDP_ADDR_PORT_DATA     12'h044
`define SDP_ADDR_FRAME_RELOAD  12'h048
`define SDP_ADDR_LOW_RELOAD    12'h04c
`define SDP_ADDR_DYN_DUTY_A    12'h050
`define SDP_ADDR_DYN_DUTY_B    12'h054
`define SDP_ADDR_DYN_STATUS    12'h058
`define SDP_ADDR_PIN_LEVEL     12'h05c
// field positions
`define SDP_INVERT_BIT         7
// reset values
`define SDP_CTRL_RESET         8'h00
`define SDP_DUTY_RESET         8'h00
`define SDP_LOW_RELOAD_RESET   8'h00
`define SDP_FRAME_RELOAD_RESET 8'hff
// counter advances once every two oscillator periods
`define SDP_PRESCALE_CYCLES    2
`endif

// file: rtl/sdp_pkg.sv
package sdp_pkg;
	typedef logic [7:0] sdp_byte_t;
	typedef enum logic [1:0] {
		SDP_PIN_PORT  = 2'b01,
		SDP_PIN_PULSE = 2'b10
	} sdp_pin_fn_t;
endpackage

// file: rtl/sdp_pwm.sv
`timescale 1ns/10ps
`include "sdp_map.svh"
module sdp_pwm
	import sdp_pkg::*;
#(
	parameter int CHANNELS = 8
) (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                verticalSyncInput,
	input  wire logic [CHANNELS-1:0] staticPinIn,
	output logic      [CHANNELS-1:0] staticPinOut,
	output logic      [CHANNELS-1:0] staticPinOe,
	output logic                     dynamicPulseOutA,
	output logic                     dynamicPulseOeA,
	output logic                     dynamicPulseOutB,
	output logic                     dynamicPulseOeB
);

	sdp_byte_t             staticCtrl_r;
	sdp_byte_t             dynamicCtrl_r;
	sdp_byte_t             duty_r [CHANNELS];
	logic [CHANNELS-1:0]   portSel_r;
	logic [CHANNELS-1:0]   portData_r;
	sdp_byte_t             frameReload_r;
	sdp_byte_t             lowReload_r;
	sdp_byte_t             dynDutyA_r;
	sdp_byte_t             dynDutyB_r;
	logic                  prescale_r;
	sdp_byte_t             staticCount_r;
	sdp_byte_t             lowCount_r;
	sdp_byte_t             blockCount_r;
	logic                  vsMeta_r;
	logic                  vsSync_r;
	logic                  vsPrev_r;
	logic [CHANNELS-1:0]   pinMeta_r;
	logic [CHANNELS-1:0]   pinSync_r;
	logic                  frameStart;
	logic                  lowWrap;
	logic                  tick;
	logic                  wrEn;
	logic                  rdEn;
	logic                  hit;
	logic [31:0]           rdVal;
	logic [CHANNELS-1:0]   staticLevel;
	logic                  levelA;
	logic                  levelB;

	// high while duty compare is at or above counter, low then when inv is set
	function automatic logic pulse_level(input sdp_byte_t duty, input sdp_byte_t cnt,
	                                     input logic inv);
		pulse_level = (duty >= cnt) ^ inv;
	endfunction

	function automatic logic [1:0] pin_drive(input logic lvl, input logic pushPull);
		// open drain drives only low
		pin_drive = pushPull ? {1'b1, lvl} : {~lvl, 1'b0};
	endfunction

	// duty register n sits one word above duty register n - 1
	function automatic logic duty_hit(input logic [11:0] addr, input int idx);
		duty_hit = addr == (`SDP_ADDR_DUTY_BASE + 12'(4 * idx));
	endfunction

	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && !penable && !pwrite;
	assign tick = prescale_r;
	assign lowWrap = tick && (lowCount_r == 8'hff);
	assign frameStart = vsSync_r && !vsPrev_r;

	// static control: invert and drive type bits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			staticCtrl_r <= `SDP_CTRL_RESET;
		end else if (wrEn && paddr == `SDP_ADDR_STATIC_CTRL) begin
			staticCtrl_r <= pwdata[7:0];
		end
	end

	// dynamic control: bits 6..2 stay zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dynamicCtrl_r <= `SDP_CTRL_RESET;
		end else if (wrEn && paddr == `SDP_ADDR_DYNAMIC_CTRL) begin
			dynamicCtrl_r <= {pwdata[7], 5'h00, pwdata[1:0]};
		end
	end

	// port function select
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			portSel_r <= '0;
		end else if (wrEn && paddr == `SDP_ADDR_PORT_SEL) begin
			portSel_r <= pwdata[CHANNELS-1:0];
		end
	end

	// port data bits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			portData_r <= '0;
		end else if (wrEn && paddr == `SDP_ADDR_PORT_DATA) begin
			portData_r <= pwdata[CHANNELS-1:0];
		end
	end

	// blocks per frame reload
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frameReload_r <= `SDP_FRAME_RELOAD_RESET;
		end else if (wrEn && paddr == `SDP_ADDR_FRAME_RELOAD) begin
			frameReload_r <= pwdata[7:0];
		end
	end

	// low counter reload
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lowReload_r <= `SDP_LOW_RELOAD_RESET;
		end else if (wrEn && paddr == `SDP_ADDR_LOW_RELOAD) begin
			lowReload_r <= pwdata[7:0];
		end
	end

	// dynamic channel a duty
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dynDutyA_r <= `SDP_DUTY_RESET;
		end else if (wrEn && paddr == `SDP_ADDR_DYN_DUTY_A) begin
			dynDutyA_r <= pwdata[7:0];
		end
	end

	// dynamic channel b duty
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dynDutyB_r <= `SDP_DUTY_RESET;
		end else if (wrEn && paddr == `SDP_ADDR_DYN_DUTY_B) begin
			dynDutyB_r <= pwdata[7:0];
		end
	end

	// static duty compare values
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < CHANNELS; i++) begin
				duty_r[i] <= `SDP_DUTY_RESET;
			end
		end else if (wrEn) begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (duty_hit(paddr, i)) begin
					duty_r[i] <= pwdata[7:0];
				end
			end
		end
	end

	// read decode
	always_comb begin
		rdVal = 32'h0000_0000;
		hit = 1'b1;
		case (paddr)
			`SDP_ADDR_STATIC_CTRL:  rdVal[7:0] = staticCtrl_r;
			`SDP_ADDR_DYNAMIC_CTRL: rdVal[7:0] = dynamicCtrl_r;
			`SDP_ADDR_PORT_SEL:     rdVal[CHANNELS-1:0] = portSel_r;
			`SDP_ADDR_PORT_DATA:    rdVal[CHANNELS-1:0] = portData_r;
			`SDP_ADDR_FRAME_RELOAD: rdVal[7:0] = frameReload_r;
			`SDP_ADDR_LOW_RELOAD:   rdVal[7:0] = lowReload_r;
			`SDP_ADDR_DYN_DUTY_A:   rdVal[7:0] = dynDutyA_r;
			`SDP_ADDR_DYN_DUTY_B:   rdVal[7:0] = dynDutyB_r;
			`SDP_ADDR_DYN_STATUS:   rdVal[15:0] = {blockCount_r, lowCount_r};
			`SDP_ADDR_PIN_LEVEL:    rdVal[CHANNELS-1:0] = pinSync_r;
			default: begin
				hit = 1'b0;
				for (int i = 0; i < CHANNELS; i++) begin
					if (duty_hit(paddr, i)) begin
						rdVal[7:0] = duty_r[i];
						hit = 1'b1;
					end
				end
			end
		endcase
	end

	// apb ready: one wait-free access phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	// apb error: unmapped address refused
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !hit;
		end
	end

	// apb read data captured in the setup cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (rdEn) begin
			prdata <= hit ? rdVal : 32'h0000_0000;
		end
	end

	// divide by two
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prescale_r <= 1'b0;
		end else begin
			prescale_r <= ~prescale_r;
		end
	end

	// static counter wraps modulo 256
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			staticCount_r <= 8'h00;
		end else if (tick) begin
			staticCount_r <= staticCount_r + 8'h01;
		end
	end

	// vertical sync synchroniser
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vsMeta_r <= 1'b0;
			vsSync_r <= 1'b0;
		end else begin
			vsMeta_r <= verticalSyncInput;
			vsSync_r <= vsMeta_r;
		end
	end

	// last synchronised level for the frame edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vsPrev_r <= 1'b0;
		end else begin
			vsPrev_r <= vsSync_r;
		end
	end

	// port pin synchroniser for read-back
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
		end else begin
			pinMeta_r <= staticPinIn;
			pinSync_r <= pinMeta_r;
		end
	end

	// timer2 low byte, reloads from low reload on wrap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lowCount_r <= 8'h00;
		end else if (frameStart) begin
			lowCount_r <= lowReload_r;
		end else if (tick) begin
			lowCount_r <= (lowCount_r == 8'hff) ? lowReload_r : lowCount_r + 8'h01;
		end
	end

	// timer2 high byte counts blocks within a frame
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blockCount_r <= 8'h00;
		end else if (frameStart) begin
			blockCount_r <= frameReload_r;
		end else if (lowWrap) begin
			blockCount_r <= (blockCount_r == 8'hff) ? frameReload_r : blockCount_r + 8'h01;
		end
	end

	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			staticLevel[i] = pulse_level(duty_r[i], staticCount_r,
			                             staticCtrl_r[`SDP_INVERT_BIT]);
		end
		levelA = pulse_level(dynDutyA_r, lowCount_r, dynamicCtrl_r[`SDP_INVERT_BIT]);
		levelB = pulse_level(dynDutyB_r, lowCount_r, dynamicCtrl_r[`SDP_INVERT_BIT]);
	end

	// registered static pin drivers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			staticPinOut <= '0;
			staticPinOe  <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (portSel_r[i]) begin
					{staticPinOe[i], staticPinOut[i]} <= {1'b1, portData_r[i]};
				end else begin
					{staticPinOe[i], staticPinOut[i]} <=
						pin_drive(staticLevel[i], (i == CHANNELS - 1) ? 1'b1 : staticCtrl_r[i]);
				end
			end
		end
	end

	// registered dynamic pin drivers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dynamicPulseOutA <= 1'b0;
			dynamicPulseOeA  <= 1'b0;
			dynamicPulseOutB <= 1'b0;
			dynamicPulseOeB  <= 1'b0;
		end else begin
			{dynamicPulseOeA, dynamicPulseOutA} <= pin_drive(levelA, dynamicCtrl_r[0]);
			{dynamicPulseOeB, dynamicPulseOutB} <= pin_drive(levelB, dynamicCtrl_r[1]);
		end
	end

endmodule // sdp_pwm

// file: test/sdp_pwm_checker.sv
`timescale 1ns/10ps
`include "sdp_map.svh"
module sdp_pwm_checker (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ready_needs_select: assert property (!psel |=> !pready)
		else $error("ready without a transfer");
	a_err_needs_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_unmapped_err: assert property (psel && !penable && paddr == 12'hffc |=> pslverr)
		else $error("unmapped address not refused");
	a_ctrl_no_err: assert property (psel && !penable && paddr == `SDP_ADDR_STATIC_CTRL |=> !pslverr)
		else $error("control register refused");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
endmodule // sdp_pwm_checker

bind sdp_pwm sdp_pwm_checker u_checker (.clk(clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

// file: test/sdp_load.sv
`timescale 1ns/10ps
module sdp_load (
	input  wire logic [9:0] pinOut,
	input  wire logic [9:0] pinOe,
	output logic      [9:0] pinLevel
);
	// pulled-up lines: a released pin reads high
	assign pinLevel = pinOut | ~pinOe;
endmodule // sdp_load

// file: test/static_and_dynamic_pwm_tb_top.sv
`timescale 1ns/10ps
`include "sdp_map.svh"
module static_and_dynamic_pwm_tb_top;
	import sdp_pkg::*;
	logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, vsync = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, hi, oe;
	logic        pready, pslverr;
	logic [9:0]  pinOut, pinOe, pinLevel;
	int          nErrors = 0, totalChecks = 0;
	always #10 clk = ~clk;
	sdp_pwm dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.verticalSyncInput(vsync), .staticPinIn(pinLevel[7:0]), .staticPinOut(pinOut[7:0]),
		.staticPinOe(pinOe[7:0]), .dynamicPulseOutA(pinOut[8]), .dynamicPulseOeA(pinOe[8]),
		.dynamicPulseOutB(pinOut[9]), .dynamicPulseOeB(pinOe[9]));
	sdp_load load (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));
	task give_verdict;
		if (nErrors == 0 && totalChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] want);
		totalChecks++;
		if (seen !== want) begin
			nErrors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			nErrors++;
			give_verdict();
		end
		rd = prdata;
		check(pslverr, err);
		psel <= 0;
		penable <= 0;
	endtask
	task measure(input int ch, input logic [31:0] wantHi, input logic [31:0] wantOe);
		hi = 0;
		oe = 0;
		repeat (514) @(posedge clk);
		repeat (512) begin
			@(posedge clk);
			hi += pinLevel[ch];
			oe += pinOe[ch];
		end
		check(hi, wantHi);
		check(oe, wantOe);
	endtask
	task regs;
		apb(0, `SDP_ADDR_STATIC_CTRL, 0, 0);
		check(rd, {24'h0, `SDP_CTRL_RESET});
		apb(0, `SDP_ADDR_FRAME_RELOAD, 0, 0);
		check(rd, {24'h0, `SDP_FRAME_RELOAD_RESET});
		apb(1, `SDP_ADDR_DYNAMIC_CTRL, 32'hffffffff, 0);
		apb(0, `SDP_ADDR_DYNAMIC_CTRL, 0, 0);
		check(rd, 32'h83);
		apb(0, 12'hffc, 0, 1);
		check(rd, 32'h0);
	endtask
	task ports;
		apb(1, `SDP_ADDR_PORT_DATA, 32'ha5, 0);
		apb(1, `SDP_ADDR_PORT_SEL, 32'hff, 0);
		repeat (4) @(posedge clk);
		check(pinOe[7:0], 8'hff);
		check(pinOut[7:0], 8'ha5);
		apb(0, `SDP_ADDR_PIN_LEVEL, 0, 0);
		check(rd, 32'ha5);
		apb(1, `SDP_ADDR_PORT_SEL, 32'h00, 0);
	endtask
	task statics;
		apb(1, `SDP_ADDR_DUTY_BASE, 32'h3f, 0);
		apb(1, `SDP_ADDR_DUTY_BASE + 12'h01c, 32'hff, 0);
		apb(1, `SDP_ADDR_STATIC_CTRL, 32'h7f, 0);
		measure(0, 128, 512);
		measure(1, 2, 512);
		measure(7, 512, 512);
		apb(1, `SDP_ADDR_STATIC_CTRL, 32'h80, 0);
		measure(0, 384, 128);
		measure(7, 0, 512);
	endtask
	task dynamics;
		apb(1, `SDP_ADDR_LOW_RELOAD, 32'h0, 0);
		apb(1, `SDP_ADDR_DYN_DUTY_A, 32'h3f, 0);
		apb(1, `SDP_ADDR_DYN_DUTY_B, 32'h0, 0);
		apb(1, `SDP_ADDR_DYNAMIC_CTRL, 32'h03, 0);
		measure(8, 128, 512);
		measure(9, 2, 512);
		apb(1, `SDP_ADDR_DYNAMIC_CTRL, 32'h80, 0);
		measure(8, 384, 128);
		measure(9, 510, 2);
	endtask
	task frames;
		apb(1, `SDP_ADDR_FRAME_RELOAD, 32'hfe, 0);
		@(posedge clk);
		vsync <= 1;
		repeat (10) @(posedge clk);
		apb(0, `SDP_ADDR_DYN_STATUS, 0, 0);
		check(rd[15:8], 8'hfe);
		repeat (590) @(posedge clk);
		apb(0, `SDP_ADDR_DYN_STATUS, 0, 0);
		check(rd[15:8], 8'hff);
		vsync <= 0;
		repeat (505) @(posedge clk);
		apb(0, `SDP_ADDR_DYN_STATUS, 0, 0);
		check(rd[15:8], 8'hfe);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1;
		regs();
		ports();
		statics();
		dynamics();
		frames();
		give_verdict();
	end
endmodule // static_and_dynamic_pwm_tb_top
